// ---- hw/flash_regs_pkg.sv ----
// Package with constants and types for the flash status and configuration register block
//
// Overview of operation
// - Status bit 7 is nonvolatile write disable, used together with write protect pin.
// - Bit 7 set with protect pin low makes status read-only; writes ignored.
// - Status bit 5 chooses protected region at top (0) or bottom (1).
// - Status bits 4:2 protect field; nonzero blocks program/erase in region.
// - Whole-array erase runs only when protect field and top/bottom are zero.
// - Write enable latch is volatile, cleared at power-up; writes refused until set.
// - Host issues write enable first; device accepts writes only with latch set.
// - Status bit 0 shows busy during status, config write, program or erase.
// - Volatile status bits are zeroed at every power cycle or reset.
// - Status register reached only through read-status and write-status commands.
// - Configuration bits 15:12 give dummy cycles after fast-read commands.
// - Dummy codes 0000 and 1111 both mean the default setting.
// - Configuration bits 11:9 choose execute-in-place mode after power-on; 111 disabled.
// - Configuration bit 4 enables hold/reset pin function when 1.
// - Configuration bit 3 low enables four-line protocol.
// - Configuration bit 2 low enables two-line protocol.
// - Configuration register ships all ones and sets configuration after power-on.
// - Both protocol bits zero selects four-line protocol after next power-on.
// - Working configuration is loaded from nonvolatile configuration at each boot.
package flash_regs_pkg;
    // Commands
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ_NVCFG = 8'hb5;
    localparam logic [7:0] CMD_WRITE_NVCFG = 8'hb1;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;
    // Status field positions
    localparam int ST_WIP_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_PROT_LO = 2;
    localparam int ST_PROT_HI = 4;
    localparam int ST_TB_BIT = 5;
    localparam int ST_WD_BIT = 7;
    localparam logic [7:0] ST_NV_MASK = 8'hbc;
    localparam logic [7:0] ST_RESET = 8'h00;
    // Configuration field positions
    localparam int CF_DUMMY_LO = 12;
    localparam int CF_XIP_LO = 9;
    localparam int CF_DRV_LO = 6;
    localparam int CF_HOLD_BIT = 4;
    localparam int CF_QUAD_BIT = 3;
    localparam int CF_DUAL_BIT = 2;
    localparam logic [15:0] CF_RESET = 16'hffff;
    localparam logic [3:0] DUMMY_DEFAULT = 4'hf;
    // Busy times in clk_sys cycles
    localparam int WRITE_TIME_CYCLES = 16;
    localparam logic [7:0] BUSY_CYCLES = 8'(WRITE_TIME_CYCLES);

    typedef enum logic [2:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
    typedef enum logic [2:0] {S_IDLE, S_CMD, S_DATA, S_WAIT_CS} phase_t;

    typedef struct packed {
        logic [3:0] dummy_cycles;
        logic [2:0] execute_in_place_mode;
        logic [2:0] drive_strength;
        logic hold_enable;
        proto_t protocol;
    } work_cfg_t;

    typedef struct packed {
        logic busy;
        logic [7:0] status;
        logic [15:0] nvcfg;
        logic bulk_rejected;
        logic program_rejected;
    } flags_t;
endpackage

// ---- hw/flash_status_and_nv_config_regs.sv ----
// Status and nonvolatile configuration register logic on the serial command interface
`timescale 1ns/10ps
module flash_status_and_nv_config_regs
    import flash_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic write_protect_n,
    input wire logic [23:0] target_page,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    output work_cfg_t work_cfg,
    output flags_t flags,
    output logic array_write_go
);

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] wp_s;
        logic sck_d;
        phase_t phase;
        logic [7:0] cmd;
        logic [5:0] bitcnt;
        logic [23:0] shift_in;
        logic [15:0] shift_out;
        logic [7:0] status;
        logic [15:0] nvcfg;
        logic [7:0] busy_cnt;
        logic [15:0] pend_cfg;
        logic [7:0] pend_st;
        logic [1:0] pend_kind;
        logic miso;
        logic miso_oe_n;
        logic boot;
        work_cfg_t work;
        logic bulk_rej;
        logic prog_rej;
        logic go;
    } state_t;

    // Power-up contents: the nonvolatile configuration leaves the factory fully erased, nonvolatile status bits all zero
    state_t state_reg = '{
        nvcfg: CF_RESET,
        cs_s: 2'b11,
        wp_s: 2'b11,
        phase: S_IDLE,
        miso_oe_n: 1'b1,
        boot: 1'b1,
        work: '{DUMMY_DEFAULT, 3'h7, 3'h7, 1'b1, PROTO_EXT},
        default: '0
    };
    state_t state_next;

    logic sck_rise;
    logic sck_fall;
    logic cs_hi;
    logic wp_low;
    logic locked;
    logic [2:0] prot_field;
    logic prot_any;
    logic page_in_region;
    logic [7:0] in_byte;

    assign sck_rise = state_reg.sck_s[1] & ~state_reg.sck_d;
    assign sck_fall = ~state_reg.sck_s[1] & state_reg.sck_d;
    assign cs_hi = state_reg.cs_s[1];
    assign wp_low = ~state_reg.wp_s[1];
    assign locked = state_reg.status[ST_WD_BIT] & wp_low;
    assign prot_field = state_reg.status[ST_PROT_HI:ST_PROT_LO];
    assign prot_any = |prot_field;
    assign in_byte = {state_reg.shift_in[6:0], state_reg.mosi_s[1]};

    // Coarse region check on the top address bits: protected size doubles with each field step, except top-side 7, which covers all blocks
    always_comb
    begin
        logic [6:0] blk;
        logic [6:0] lim;
        blk = target_page[22:16];
        lim = 7'(7'h01 << (prot_field - 3'h1));
        if (!prot_any)
        begin
            page_in_region = 1'b0;
        end
        else if (state_reg.status[ST_TB_BIT])
        begin
            page_in_region = (blk < lim);
        end
        else
        begin
            page_in_region = (blk >= 7'(7'h00 - lim)) || (prot_field == 3'h7);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_next = state_reg;
        state_next.sck_s = {state_reg.sck_s[0], spi_sck};
        state_next.cs_s = {state_reg.cs_s[0], spi_cs_n};
        state_next.mosi_s = {state_reg.mosi_s[0], spi_mosi};
        state_next.wp_s = {state_reg.wp_s[0], write_protect_n};
        state_next.sck_d = state_reg.sck_s[1];
        state_next.go = 1'b0;

        // Working configuration loaded once after reset
        if (state_reg.boot)
        begin
            state_next.boot = 1'b0;
            state_next.work.dummy_cycles = state_reg.nvcfg[CF_DUMMY_LO +: 4];
            if (state_reg.nvcfg[CF_DUMMY_LO +: 4] == 4'h0)
            begin
                state_next.work.dummy_cycles = DUMMY_DEFAULT;
            end
            state_next.work.execute_in_place_mode = state_reg.nvcfg[CF_XIP_LO +: 3];
            state_next.work.drive_strength = state_reg.nvcfg[CF_DRV_LO +: 3];
            state_next.work.hold_enable = state_reg.nvcfg[CF_HOLD_BIT];
            if (!state_reg.nvcfg[CF_QUAD_BIT])
            begin
                state_next.work.protocol = PROTO_QUAD;
            end
            else if (!state_reg.nvcfg[CF_DUAL_BIT])
            begin
                state_next.work.protocol = PROTO_DUAL;
            end
            else
            begin
                state_next.work.protocol = PROTO_EXT;
            end
        end

        // Internal write cycle timer
        if (state_reg.busy_cnt != 8'h00)
        begin
            state_next.busy_cnt = state_reg.busy_cnt - 8'h01;
            if (state_reg.busy_cnt == 8'h01)
            begin
                if (state_reg.pend_kind == 2'd1)
                begin
                    state_next.status = (state_reg.status & ~ST_NV_MASK)
                        | (state_reg.pend_st & ST_NV_MASK);
                end
                else if (state_reg.pend_kind == 2'd2)
                begin
                    state_next.nvcfg = state_reg.pend_cfg;
                end
                state_next.status[ST_WEL_BIT] = 1'b0;
                state_next.status[ST_WIP_BIT] = 1'b0;
            end
        end

        // Serial command engine, mode 0: sample on rise, shift out on fall
        if (cs_hi)
        begin
            state_next.phase = S_IDLE;
            state_next.bitcnt = 6'd0;
            state_next.miso_oe_n = 1'b1;
            if (state_reg.phase == S_DATA && state_reg.busy_cnt == 8'h00)
            begin
                if (state_reg.cmd == CMD_WRITE_STATUS && state_reg.bitcnt >= 6'd8
                    && state_reg.status[ST_WEL_BIT] && !locked)
                begin
                    state_next.pend_st = state_reg.shift_in[7:0];
                    state_next.pend_kind = 2'd1;
                    state_next.busy_cnt = BUSY_CYCLES;
                    state_next.status[ST_WIP_BIT] = 1'b1;
                end
                else if (state_reg.cmd == CMD_WRITE_NVCFG && state_reg.bitcnt >= 6'd16
                    && state_reg.status[ST_WEL_BIT])
                begin
                    state_next.pend_cfg = {state_reg.shift_in[7:0], state_reg.shift_in[15:8]};
                    state_next.pend_kind = 2'd2;
                    state_next.busy_cnt = BUSY_CYCLES;
                    state_next.status[ST_WIP_BIT] = 1'b1;
                end
                else if ((state_reg.cmd == CMD_PAGE_PROGRAM || state_reg.cmd == CMD_SECTOR_ERASE)
                    && state_reg.status[ST_WEL_BIT])
                begin
                    if (page_in_region)
                    begin
                        state_next.prog_rej = 1'b1;
                    end
                    else
                    begin
                        state_next.pend_kind = 2'd3;
                        state_next.busy_cnt = BUSY_CYCLES;
                        state_next.status[ST_WIP_BIT] = 1'b1;
                        state_next.go = 1'b1;
                        state_next.prog_rej = 1'b0;
                    end
                end
            end
            if (state_reg.phase == S_CMD && state_reg.bitcnt == 6'd8
                && state_reg.busy_cnt == 8'h00 && state_reg.status[ST_WEL_BIT]
                && state_reg.cmd == CMD_BULK_ERASE)
            begin
                if (prot_any || state_reg.status[ST_TB_BIT])
                begin
                    state_next.bulk_rej = 1'b1;
                end
                else
                begin
                    state_next.bulk_rej = 1'b0;
                    state_next.pend_kind = 2'd3;
                    state_next.busy_cnt = BUSY_CYCLES;
                    state_next.status[ST_WIP_BIT] = 1'b1;
                    state_next.go = 1'b1;
                end
            end
        end
        else
        begin
            if (state_reg.phase == S_IDLE)
            begin
                state_next.phase = S_CMD;
            end
            if (sck_rise)
            begin
                state_next.shift_in = {state_reg.shift_in[22:0], state_reg.mosi_s[1]};
                state_next.bitcnt = (state_reg.bitcnt == 6'd63) ? 6'd63 : state_reg.bitcnt + 6'd1;
                if ((state_reg.phase == S_CMD || state_reg.phase == S_IDLE)
                    && state_reg.bitcnt == 6'd7)
                begin
                    state_next.cmd = in_byte;
                    state_next.phase = S_DATA;
                    state_next.bitcnt = 6'd0;
                    // Register access only by its dedicated commands
                    if (in_byte == CMD_READ_STATUS)
                    begin
                        state_next.shift_out = {state_reg.status, state_reg.status};
                    end
                    else if (in_byte == CMD_READ_NVCFG)
                    begin
                        state_next.shift_out = {state_reg.nvcfg[7:0], state_reg.nvcfg[15:8]};
                    end
                    else if (in_byte == CMD_WRITE_ENABLE && state_reg.busy_cnt == 8'h00)
                    begin
                        state_next.status[ST_WEL_BIT] = 1'b1;
                    end
                    else if (in_byte == CMD_WRITE_DISABLE && state_reg.busy_cnt == 8'h00)
                    begin
                        state_next.status[ST_WEL_BIT] = 1'b0;
                    end
                    else if (in_byte == CMD_BULK_ERASE)
                    begin
                        state_next.phase = S_CMD;
                        state_next.bitcnt = 6'd8;
                    end
                end
            end
            if (sck_fall && state_reg.phase == S_DATA
                && (state_reg.cmd == CMD_READ_STATUS || state_reg.cmd == CMD_READ_NVCFG))
            begin
                state_next.miso = state_reg.shift_out[15];
                state_next.miso_oe_n = 1'b0;
                if (state_reg.cmd == CMD_READ_STATUS)
                begin
                    state_next.shift_out = {state_reg.shift_out[14:0], state_reg.status[7]};
                end
                else
                begin
                    state_next.shift_out = {state_reg.shift_out[14:0], state_reg.shift_out[15]};
                end
            end
            if (state_reg.phase == S_DATA && state_reg.cmd == CMD_READ_STATUS && sck_fall)
            begin
                // Live write-disable bit 7 on repeated status reads
                state_next.shift_out[15:8] = {state_reg.shift_out[14:8], state_reg.status[7]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.sck_s <= 2'b00;
            state_reg.cs_s <= 2'b11;
            state_reg.wp_s <= 2'b11;
            state_reg.phase <= S_IDLE;
            state_reg.status <= state_reg.status & ST_NV_MASK;
            // Reset keeps the stored configuration; only power-up sets it
            state_reg.nvcfg <= state_reg.nvcfg;
            state_reg.miso_oe_n <= 1'b1;
            state_reg.boot <= 1'b1;
            state_reg.work <= '{DUMMY_DEFAULT, 3'h7, 3'h7, 1'b1, PROTO_EXT};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign spi_miso = state_reg.miso;
    assign spi_miso_oe_n = state_reg.miso_oe_n;
    assign work_cfg = state_reg.work;
    assign array_write_go = state_reg.go;
    assign flags = '{state_reg.busy_cnt != 8'h00, state_reg.status, state_reg.nvcfg,
                     state_reg.bulk_rej, state_reg.prog_rej};

endmodule

// ---- sim/flash_regs_monitor.sv ----
// Port checker for the flash status and configuration registers
`timescale 1ns/10ps
module flash_regs_monitor
    import flash_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic write_protect_n,
    input wire logic spi_miso_oe_n,
    input wire work_cfg_t work_cfg,
    input wire flags_t flags,
    input wire logic array_write_go
);
    logic seen_wr_reg = 1'b0;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Nonvolatile contents are known only after a finished write cycle
    always_ff @(posedge clk_sys)
    begin
        if ($fell(flags.busy))
        begin
            seen_wr_reg <= 1'b1;
        end
    end
    sequence wr_done_s;
        $fell(flags.status[ST_WIP_BIT]);
    endsequence
    sequence cfg_loaded_s;
        seen_wr_reg && $fell(rst) ##2 1'b1;
    endsequence
    busy_len_a: assert property ($rose(flags.busy) |->
        flags.busy[*8] ##8 flags.busy ##1 !flags.busy) else $error("busy length wrong");
    wel_clear_a: assert property (wr_done_s |-> !flags.status[ST_WEL_BIT])
        else $error("write enable kept after cycle");
    go_pulse_a: assert property (array_write_go |=> !array_write_go)
        else $error("start pulse too long");
    go_wel_a: assert property (array_write_go |-> flags.status[ST_WEL_BIT])
        else $error("array write without enable");
    wp_lock_a: assert property ((flags.status[ST_WD_BIT] && !write_protect_n)[*4]
        |=> $stable(flags.status & ST_NV_MASK)) else $error("locked status changed");
    idle_hiz_a: assert property (spi_cs_n[*5] |-> spi_miso_oe_n)
        else $error("output driven while deselected");
    bulk_block_a: assert property ($rose(flags.bulk_rejected) |->
        flags.status[4:2] != 3'b000 || flags.status[ST_TB_BIT]) else $error("bulk refused");
    reset_clear_a: assert property ($fell(rst) |->
        flags.status[1:0] == 2'b00 && spi_miso_oe_n) else $error("volatile bits kept");
    cfg_load_a: assert property (cfg_loaded_s |->
        {work_cfg.execute_in_place_mode, work_cfg.drive_strength, work_cfg.hold_enable}
        == {flags.nvcfg[11:6], flags.nvcfg[CF_HOLD_BIT]}) else $error("config not loaded");
    dummy_map_a: assert property (cfg_loaded_s |-> work_cfg.dummy_cycles ==
        (flags.nvcfg[15:12] == 4'h0 ? DUMMY_DEFAULT : flags.nvcfg[15:12]))
        else $error("dummy code wrong");
    quad_sel_a: assert property (cfg_loaded_s |->
        (work_cfg.protocol == PROTO_QUAD) == !flags.nvcfg[CF_QUAD_BIT])
        else $error("protocol wrong");
endmodule
bind flash_status_and_nv_config_regs flash_regs_monitor flash_regs_monitor_inst (.clk_sys,
    .rst, .spi_cs_n, .write_protect_n, .spi_miso_oe_n, .work_cfg, .flags, .array_write_go);

// ---- sim/spi_host_model.sv ----
// Serial host that frames flash commands, mode 0, clock parked low
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk_sys,
    input wire logic spi_miso,
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi
);
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Command then nb bytes, low byte first; 400 ns bit time
    task automatic xfer(input logic [7:0] c, input logic [15:0] wd, input int nb,
                        output logic [15:0] rd);
        logic [23:0] sh;
        logic [23:0] rx;
        sh = {c, wd[7:0], wd[15:8]};
        rx = 24'h000000;
        @(posedge clk_sys) spi_cs_n <= 1'b0;
        for (int i = 0; i < 8 + 8 * nb; i++)
        begin
            @(posedge clk_sys) spi_mosi <= sh[23 - i];
            repeat (4) @(posedge clk_sys);
            spi_sck <= 1'b1;
            rx = {rx[22:0], spi_miso};
            repeat (3) @(posedge clk_sys);
            spi_sck <= 1'b0;
        end
        @(posedge clk_sys) spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (4) @(posedge clk_sys);
        rd = nb == 2 ? {rx[7:0], rx[15:8]} : {8'h00, rx[7:0]};
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the flash status and configuration registers
`timescale 1ns/10ps
module tb_top;
    import flash_regs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic write_protect_n = 1'b1;
    logic [23:0] target_page = 24'h000000;
    logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, array_write_go, miso_line;
    work_cfg_t work_cfg;
    flags_t flags;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_go = 0;
    int st_m;
    logic [15:0] rd, c;
    logic [15:0] cfgs [$] = {16'h0000, 16'h3bfb, 16'hf7f7, 16'hffff, 16'h1855, 16'h2255,
        16'h4400};
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (array_write_go === 1'b1) n_go <= n_go + 1;
    // Released data line shows the inverse of its last value
    assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
    flash_status_and_nv_config_regs flash_status_and_nv_config_regs_inst (.clk_sys, .rst,
        .spi_sck, .spi_cs_n, .spi_mosi, .write_protect_n, .target_page, .spi_miso,
        .spi_miso_oe_n, .work_cfg, .flags, .array_write_go);
    spi_host_model spi_host_model_inst (.clk_sys, .spi_miso(miso_line), .spi_sck, .spi_cs_n,
        .spi_mosi);
    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] wd, input int nb);
        spi_host_model_inst.xfer(op, wd, nb, rd);
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 100 && flags.busy !== 1'b0; k++) @(posedge clk_sys);
        if (k == 100)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: busy never ended", $time);
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] op, input logic [15:0] v, input int nb);
        cmd(CMD_WRITE_ENABLE, 16'h0000, 0);
        cmd(op, v, nb);
        settle();
    endtask
    task automatic st_is(input logic [7:0] e);
        cmd(CMD_READ_STATUS, 16'h0000, 1);
        chk(rd, {8'h00, e});
        chk({8'h00, flags.status}, {8'h00, e});
    endtask
    task automatic prot(input logic [7:0] s, input logic [6:0] b, input logic [7:0] op,
                        input logic we, input logic go);
        int g;
        wr(CMD_WRITE_STATUS, {8'h00, s}, 1);
        target_page <= {1'b0, b, 16'($urandom())};
        g = n_go;
        if (we) cmd(CMD_WRITE_ENABLE, 16'h0000, 0);
        cmd(op, 16'h0000, 0);
        settle();
        chk(16'(n_go - g), {15'h0000, go});
        if (op == CMD_BULK_ERASE) chk({15'h0000, flags.bulk_rejected}, {15'h0000, !go});
        else chk({15'h0000, flags.program_rejected}, {15'h0000, we && !go});
    endtask
    initial
    begin
        void'($urandom(7));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmd(CMD_READ_NVCFG, 16'h0000, 2);
        chk(rd, CF_RESET);
        chk({12'h000, work_cfg.dummy_cycles}, {12'h000, DUMMY_DEFAULT});
        wr(CMD_WRITE_STATUS, 16'h0000, 1);
        st_m = 0;
        st_is(8'(st_m));
        cmd(CMD_WRITE_STATUS, 16'h001c, 1);
        settle();
        st_is(8'(st_m));
        cmd(CMD_WRITE_ENABLE, 16'h0000, 0);
        st_is(8'h02);
        repeat (4)
        begin
            st_m = $urandom() & 32'hff;
            wr(CMD_WRITE_STATUS, 16'(st_m), 1);
            st_m = st_m & ST_NV_MASK;
            st_is(8'(st_m));
        end
        wr(CMD_WRITE_STATUS, 16'h0080, 1);
        write_protect_n <= 1'b0;
        wr(CMD_WRITE_STATUS, 16'h003c, 1);
        cmd(CMD_READ_STATUS, 16'h0000, 1);
        chk(rd & 16'h00bc, 16'h0080);
        write_protect_n <= 1'b1;
        wr(CMD_WRITE_STATUS, 16'h0000, 1);
        st_is(8'h00);
        prot(8'h04, 7'h7f, CMD_PAGE_PROGRAM, 1'b1, 1'b0);
        prot(8'h04, 7'h00, CMD_PAGE_PROGRAM, 1'b1, 1'b1);
        prot(8'h24, 7'h00, CMD_SECTOR_ERASE, 1'b1, 1'b0);
        prot(8'h24, 7'h7f, CMD_SECTOR_ERASE, 1'b1, 1'b1);
        prot(8'h00, 7'h05, CMD_PAGE_PROGRAM, 1'b0, 1'b0);
        prot(8'h04, 7'h00, CMD_BULK_ERASE, 1'b1, 1'b0);
        prot(8'h20, 7'h00, CMD_BULK_ERASE, 1'b1, 1'b0);
        prot(8'h00, 7'h00, CMD_BULK_ERASE, 1'b1, 1'b1);
        cfgs.push_back(16'($urandom()));
        foreach (cfgs[i])
        begin
            c = cfgs[i];
            wr(CMD_WRITE_NVCFG, c, 2);
            cmd(CMD_READ_NVCFG, 16'h0000, 2);
            chk(rd, c);
            cmd(CMD_WRITE_ENABLE, 16'h0000, 0);
            rst <= 1'b1;
            repeat (2) @(posedge clk_sys);
            rst <= 1'b0;
            repeat (4) @(posedge clk_sys);
            chk({14'h0000, flags.status[1:0]}, 16'h0000);
            chk({work_cfg.dummy_cycles, work_cfg.execute_in_place_mode, work_cfg.drive_strength,
                5'h00, work_cfg.hold_enable}, {c[15:12] == 4'h0 ? 4'hf : c[15:12], c[11:6],
                5'h00, c[4]});
            chk(16'(work_cfg.protocol), 16'(!c[3] ? PROTO_QUAD : !c[2] ? PROTO_DUAL
                : PROTO_EXT));
        end
        report_and_stop();
    end
endmodule
